// [ddr3_pkg.sv]
package ddr3_pkg;

  // Link clock period used to turn times into cycles
  localparam int CK_PERIOD_PS = 12000;

  // Analog minimums, in picoseconds
  localparam int T_RAS_PS = 35000;
  localparam int T_RTP_PS = 7500;
  localparam int T_RP_PS  = 15000;

  // Rounds a minimum time up to whole link cycles, never below one
  function automatic int ck_cycles(input int t_ps);
    int n;
    n = (t_ps + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
    return (n < 1) ? 1 : n;
  endfunction

  localparam int TRAS_CK         = ck_cycles(T_RAS_PS);
  localparam int TRTP_CK         = ck_cycles(T_RTP_PS);
  localparam int TRP_CK          = ck_cycles(T_RP_PS);
  localparam int PREFETCH_GAP_CK = 4;
  localparam int AP_MIN_CK       = (TRTP_CK > PREFETCH_GAP_CK) ? TRTP_CK : PREFETCH_GAP_CK;

  // Counts given directly in link cycles
  localparam int TMRD_CK    = 4;
  localparam int TMOD_CK    = 12;
  localparam int TCCD_CK    = 4;
  localparam int TZQINIT_CK = 512;
  localparam int TZQOPER_CK = 256;
  localparam int TZQCS_CK   = 64;

  // Pin widths, bank count and mode register count
  localparam int BA_W  = 3;
  localparam int A_W   = 14;
  localparam int COL_W = 10;
  localparam int NBANK = 8;
  localparam int NMR   = 4;

  // Address bits with a meaning on the command
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  // Mode register fields
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam int CL_W      = 4;
  localparam int MR_AL_LSB = 3;
  localparam int AL_W      = 3;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;

  // Reset values, MR3 in the top slice down to MR0
  localparam logic [NMR*A_W-1:0] MR_RST = {14'h0000, 14'h0000, 14'h0000, 14'h0050};

  // Command codes on {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_ZQ  = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;

  localparam int STAT_W = NMR * A_W + NBANK + 2;

  typedef enum logic {ZQ_IDLE, ZQ_BUSY} zq_t;

endpackage

// [bank_timer.sv]
`timescale 1ns/1ns
module bank_timer
  import ddr3_pkg::*;
#(
  parameter int TRAS   = ddr3_pkg::TRAS_CK,
  parameter int AP_MIN = ddr3_pkg::AP_MIN_CK,
  parameter int TRP    = ddr3_pkg::TRP_CK
)(
  // Link clock
  input  wire logic                      ck,
  input  wire logic                      rst_n,
  // Accepted commands for this bank
  input  wire logic                      act,
  input  wire logic                      pre,
  input  wire logic                      rd_ap,
  input  wire logic [ddr3_pkg::AL_W-1:0] al,
  // State
  output logic                           open,
  output logic                           ready
);
  localparam int CW = 8;

  logic [CW-1:0] tras_reg;
  logic [CW-1:0] ap_reg;
  logic [CW-1:0] trp_reg;
  logic          ap_pend_reg;

  wire [CW-1:0] ap_len  = CW'(al) + CW'(AP_MIN);
  wire          ap_fire = ap_pend_reg & (ap_reg == '0) & (tras_reg == '0);

  assign ready = (trp_reg == '0);

  always_ff @(posedge ck or negedge rst_n) begin
    if (!rst_n) begin
      tras_reg    <= '0;
      ap_reg      <= '0;
      trp_reg     <= '0;
      ap_pend_reg <= 1'b0;
      open        <= 1'b0;
    end else begin
      if (tras_reg != '0) tras_reg <= tras_reg - CW'(1);
      if (ap_reg != '0) ap_reg <= ap_reg - CW'(1);
      if (trp_reg != '0) trp_reg <= trp_reg - CW'(1);
      if (pre) begin
        // Latest precharge restarts the period
        open        <= 1'b0;
        ap_pend_reg <= 1'b0;
        trp_reg     <= CW'(TRP - 1);
      end else if (act) begin
        open     <= 1'b1;
        tras_reg <= CW'(TRAS - 1);
      end else if (rd_ap) begin
        ap_pend_reg <= 1'b1;
        ap_reg      <= ap_len - CW'(1);
      end else if (ap_fire) begin
        // Held off by the row lockout until the row has been open long enough
        open        <= 1'b0;
        ap_pend_reg <= 1'b0;
        trp_reg     <= CW'(TRP - 1);
      end
    end
  end
endmodule

// [ddr3_command_read_timing.sv]
`timescale 1ns/1ns
module ddr3_command_read_timing
#(
  parameter int DQ_W   = 8,
  parameter int MAX_RL = 32
)(
  // System side
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  // Command pins, synchronous to the link clock
  input  wire logic                         ck,
  input  wire logic                         cke,
  input  wire logic                         cs_n,
  input  wire logic                         ras_n,
  input  wire logic                         cas_n,
  input  wire logic                         we_n,
  input  wire logic [ddr3_pkg::BA_W-1:0]    ba,
  input  wire logic [ddr3_pkg::A_W-1:0]     addr,
  // Read data pins, one value per clock half
  output logic [DQ_W-1:0]                   dq_rise,
  output logic [DQ_W-1:0]                   dq_fall,
  output logic                              dq_oe,
  output logic                              dqs_rise,
  output logic                              dqs_fall,
  output logic                              dqs_n_rise,
  output logic                              dqs_n_fall,
  output logic                              dqs_oe,
  // Core array fetch, link clock
  output logic                              core_req,
  output logic [ddr3_pkg::BA_W-1:0]         core_bank,
  output logic [ddr3_pkg::COL_W-1:0]        core_col,
  input  wire logic [8*DQ_W-1:0]            core_data,
  // Status, system clock
  output logic [ddr3_pkg::A_W-1:0]          stat_mr0,
  output logic [ddr3_pkg::A_W-1:0]          stat_mr1,
  output logic [ddr3_pkg::A_W-1:0]          stat_mr2,
  output logic [ddr3_pkg::A_W-1:0]          stat_mr3,
  output logic [ddr3_pkg::NBANK-1:0]        stat_bank_open,
  output logic                              stat_zq_busy,
  output logic                              stat_err
);
  import ddr3_pkg::*;

  localparam int PW = $clog2(MAX_RL);

  function automatic logic [DQ_W-1:0] elem(input logic [8*DQ_W-1:0] d, input logic [2:0] e);
    return d[e*DQ_W +: DQ_W];
  endfunction

  // Link reset: asserts at once, releases on the link clock
  logic ck_rst_q1_reg;
  logic ck_rst_n_reg;
  always_ff @(posedge ck or negedge arst_n) begin
    if (!arst_n) begin
      ck_rst_q1_reg <= 1'b0;
      ck_rst_n_reg  <= 1'b0;
    end else begin
      ck_rst_q1_reg <= 1'b1;
      ck_rst_n_reg  <= ck_rst_q1_reg;
    end
  end

  // Command decode
  wire       cmd_sel = cke & ~cs_n;
  wire [2:0] rcw     = {ras_n, cas_n, we_n};
  wire       is_any  = cmd_sel & (rcw != CMD_NOP);
  wire       is_mrs  = cmd_sel & (rcw == CMD_MRS);
  wire       is_pre  = cmd_sel & (rcw == CMD_PRE);
  wire       is_act  = cmd_sel & (rcw == CMD_ACT);
  wire       is_rd   = cmd_sel & (rcw == CMD_RD);
  wire       is_zq   = cmd_sel & (rcw == CMD_ZQ);

  // Mode registers: active copy and pending copy
  logic [A_W-1:0] mr_reg     [NMR];
  logic [A_W-1:0] mr_new_reg [NMR];
  logic [7:0]     tmod_reg;
  logic [7:0]     tmrd_reg;

  wire mr_hit = is_mrs & (ba[BA_W-1] == 1'b0);

  always_ff @(posedge ck or negedge ck_rst_n_reg) begin
    if (!ck_rst_n_reg) begin
      for (int i = 0; i < NMR; i++) begin
        mr_reg[i]     <= MR_RST[i*A_W +: A_W];
        mr_new_reg[i] <= MR_RST[i*A_W +: A_W];
      end
      tmod_reg <= '0;
      tmrd_reg <= '0;
    end else begin
      if (tmrd_reg != '0) tmrd_reg <= tmrd_reg - 8'h01;
      if (mr_hit) begin
        mr_new_reg[ba[1:0]] <= addr;
        tmod_reg            <= 8'(TMOD_CK);
        tmrd_reg            <= 8'(TMRD_CK - 1);
      end else if (tmod_reg > 8'h01) begin
        tmod_reg <= tmod_reg - 8'h01;
      end else if (tmod_reg == 8'h01) begin
        // Latency and burst settings switch only here
        tmod_reg <= '0;
        for (int i = 0; i < NMR; i++) mr_reg[i] <= mr_new_reg[i];
      end
    end
  end

  wire [1:0]      bl_mode  = mr_reg[0][MR_BL_LSB +: 2];
  wire [CL_W-1:0] cl       = mr_reg[0][MR_CL_LSB +: CL_W];
  wire [AL_W-1:0] al       = mr_reg[1][MR_AL_LSB +: AL_W];
  wire [PW-1:0]   rl       = PW'(cl) + PW'(al);
  wire [PW-1:0]   tap_data = rl - PW'(1);
  wire [PW-1:0]   tap_pre  = rl - PW'(2);
  wire rd_bl8 = (bl_mode == BL_FIXED8) | ((bl_mode == BL_OTF) & addr[BC_BIT]);

  // Calibration quiet period
  zq_t        zq_state;
  logic [9:0] zq_cnt_reg;
  logic       zq_first_reg;
  wire  [9:0] zq_len = !addr[AP_BIT] ? 10'(TZQCS_CK) :
                       zq_first_reg  ? 10'(TZQINIT_CK) : 10'(TZQOPER_CK);
  wire        zq_busy = (zq_state == ZQ_BUSY);

  always_ff @(posedge ck or negedge ck_rst_n_reg) begin
    if (!ck_rst_n_reg) begin
      zq_state     <= ZQ_IDLE;
      zq_cnt_reg   <= '0;
      zq_first_reg <= 1'b1;
    end else if (is_zq) begin
      // A new calibration command restarts the window
      zq_state   <= ZQ_BUSY;
      zq_cnt_reg <= zq_len - 10'h001;
      if (addr[AP_BIT]) zq_first_reg <= 1'b0;
    end else begin
      case (zq_state)
        ZQ_IDLE: zq_cnt_reg <= '0;
        ZQ_BUSY: begin
          if (zq_cnt_reg == '0) zq_state <= ZQ_IDLE;
          else zq_cnt_reg <= zq_cnt_reg - 10'h001;
        end
        default: zq_state <= ZQ_IDLE;
      endcase
    end
  end

  // Banks
  logic [NBANK-1:0] bank_open;
  logic [NBANK-1:0] bank_ready;
  wire  [NBANK-1:0] bank_sel = NBANK'(1'b1) << ba;
  wire  [NBANK-1:0] pre_vec  = addr[AP_BIT] ? {NBANK{1'b1}} : bank_sel;
  wire  act_take = is_act & ~bank_open[ba] & bank_ready[ba];
  wire  rd_take  = is_rd & bank_open[ba];
  wire  rd_ap    = rd_take & addr[AP_BIT];

  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    bank_timer u_bank (
      .ck    (ck),
      .rst_n (ck_rst_n_reg),
      .act   (act_take & bank_sel[b]),
      .pre   (is_pre & pre_vec[b]),
      .rd_ap (rd_ap & bank_sel[b]),
      .al    (al),
      .open  (bank_open[b]),
      .ready (bank_ready[b])
    );
  end

  // Protocol checks, sticky until reset
  logic [7:0] ccd_reg;
  logic       err_reg;
  wire        banks_busy = (|bank_open) | ~(&bank_ready);
  wire        err_set = (is_mrs & banks_busy)
                      | (is_zq & banks_busy)
                      | (is_any & (tmrd_reg != '0))
                      | (is_any & ~is_zq & zq_busy)
                      | (is_rd & ~bank_open[ba])
                      | (is_rd & (ccd_reg != '0))
                      | (is_act & ~bank_ready[ba])
                      | (is_act & bank_open[ba]);

  always_ff @(posedge ck or negedge ck_rst_n_reg) begin
    if (!ck_rst_n_reg) begin
      ccd_reg <= '0;
      err_reg <= 1'b0;
    end else begin
      if (rd_take) ccd_reg <= 8'(TCCD_CK - 1);
      else if (ccd_reg != '0) ccd_reg <= ccd_reg - 8'h01;
      if (err_set) err_reg <= 1'b1;
    end
  end

  // Read latency pipeline, one slot per link cycle
  logic             pv_reg   [MAX_RL];
  logic             pbl8_reg [MAX_RL];
  logic [BA_W-1:0]  pba_reg  [MAX_RL];
  logic [COL_W-1:0] pcol_reg [MAX_RL];

  always_ff @(posedge ck or negedge ck_rst_n_reg) begin
    if (!ck_rst_n_reg) begin
      for (int i = 0; i < MAX_RL; i++) begin
        pv_reg[i]   <= 1'b0;
        pbl8_reg[i] <= 1'b0;
        pba_reg[i]  <= '0;
        pcol_reg[i] <= '0;
      end
    end else begin
      pv_reg[0]   <= rd_take;
      pbl8_reg[0] <= rd_bl8;
      pba_reg[0]  <= ba;
      pcol_reg[0] <= addr[COL_W-1:0];
      for (int i = 1; i < MAX_RL; i++) begin
        pv_reg[i]   <= pv_reg[i-1];
        pbl8_reg[i] <= pbl8_reg[i-1];
        pba_reg[i]  <= pba_reg[i-1];
        pcol_reg[i] <= pcol_reg[i-1];
      end
    end
  end

  wire pre_now  = pv_reg[tap_pre];
  wire data_now = pv_reg[tap_data];

  // Burst output
  logic [8*DQ_W-1:0] buf_reg;
  logic              base_reg;
  logic [1:0]        pos_reg;
  logic [1:0]        left_reg;

  wire [2:0] s0   = {pcol_reg[tap_data][2], 2'b00};
  wire [2:0] c0   = {pos_reg, 1'b0} ^ {base_reg, 2'b00};
  wire       cont = (left_reg != '0);

  always_ff @(posedge ck or negedge ck_rst_n_reg) begin
    if (!ck_rst_n_reg) begin
      core_req  <= 1'b0;
      core_bank <= '0;
      core_col  <= '0;
    end else begin
      // Fetch one cycle ahead of the first element
      core_req  <= pre_now;
      core_bank <= pba_reg[tap_pre];
      core_col  <= pcol_reg[tap_pre];
    end
  end

  always_ff @(posedge ck or negedge ck_rst_n_reg) begin
    if (!ck_rst_n_reg) begin
      buf_reg    <= '0;
      base_reg   <= 1'b0;
      pos_reg    <= '0;
      left_reg   <= '0;
      dq_rise    <= '0;
      dq_fall    <= '0;
      dq_oe      <= 1'b0;
      dqs_rise   <= 1'b0;
      dqs_fall   <= 1'b0;
      dqs_n_rise <= 1'b1;
      dqs_n_fall <= 1'b1;
      dqs_oe     <= 1'b0;
    end else if (data_now) begin
      buf_reg    <= core_data;
      base_reg   <= pcol_reg[tap_data][2];
      pos_reg    <= 2'h1;
      left_reg   <= pbl8_reg[tap_data] ? 2'h3 : 2'h1;
      dq_rise    <= elem(core_data, s0);
      dq_fall    <= elem(core_data, s0 | 3'h1);
      dq_oe      <= 1'b1;
      dqs_rise   <= 1'b1;
      dqs_fall   <= 1'b0;
      dqs_n_rise <= 1'b0;
      dqs_n_fall <= 1'b1;
      dqs_oe     <= 1'b1;
    end else if (cont) begin
      // A new read reaching its data slot takes priority and cuts a running burst short
      pos_reg    <= pos_reg + 2'h1;
      left_reg   <= left_reg - 2'h1;
      dq_rise    <= elem(buf_reg, c0);
      dq_fall    <= elem(buf_reg, c0 | 3'h1);
      dqs_rise   <= 1'b1;
      dqs_fall   <= 1'b0;
      dqs_n_rise <= 1'b0;
      dqs_n_fall <= 1'b1;
    end else begin
      // Preamble before a burst, postamble after one; chopped pairs get a gap
      dq_rise    <= '0;
      dq_fall    <= '0;
      dq_oe      <= 1'b0;
      dqs_rise   <= 1'b0;
      dqs_fall   <= 1'b0;
      dqs_n_rise <= 1'b1;
      dqs_n_fall <= 1'b1;
      dqs_oe     <= pre_now | dq_oe;
    end
  end

  // Status word crosses to clk by request and acknowledge toggles
  wire [STAT_W-1:0] st_now = {mr_reg[3], mr_reg[2], mr_reg[1], mr_reg[0],
                              bank_open, zq_busy, err_reg};
  logic [STAT_W-1:0] snap_reg;
  logic              req_reg;
  logic              ack_q1_reg;
  logic              ack_s_reg;
  logic              ack_reg;
  logic              req_q1_reg;
  logic              req_s_reg;

  always_ff @(posedge ck or negedge ck_rst_n_reg) begin
    if (!ck_rst_n_reg) begin
      snap_reg   <= '0;
      req_reg    <= 1'b0;
      ack_q1_reg <= 1'b0;
      ack_s_reg  <= 1'b0;
    end else begin
      ack_q1_reg <= ack_reg;
      ack_s_reg  <= ack_q1_reg;
      // Snapshot only changes while no transfer is outstanding
      if ((req_reg == ack_s_reg) && (snap_reg != st_now)) begin
        snap_reg <= st_now;
        req_reg  <= ~req_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q1_reg     <= 1'b0;
      req_s_reg      <= 1'b0;
      ack_reg        <= 1'b0;
      stat_mr0       <= '0;
      stat_mr1       <= '0;
      stat_mr2       <= '0;
      stat_mr3       <= '0;
      stat_bank_open <= '0;
      stat_zq_busy   <= 1'b0;
      stat_err       <= 1'b0;
    end else begin
      req_q1_reg <= req_reg;
      req_s_reg  <= req_q1_reg;
      if (req_s_reg != ack_reg) begin
        ack_reg        <= req_s_reg;
        stat_mr3       <= snap_reg[STAT_W-1 -: A_W];
        stat_mr2       <= snap_reg[STAT_W-1-A_W -: A_W];
        stat_mr1       <= snap_reg[STAT_W-1-2*A_W -: A_W];
        stat_mr0       <= snap_reg[STAT_W-1-3*A_W -: A_W];
        stat_bank_open <= snap_reg[NBANK+1:2];
        stat_zq_busy   <= snap_reg[1];
        stat_err       <= snap_reg[0];
      end
    end
  end
endmodule

// [ddr3_command_read_timing_monitor.sv]
`timescale 1ns/1ns
module ddr3_command_read_timing_monitor (
  // Clocks and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ck,
  // Read path
  input wire logic dq_oe,
  input wire logic dqs_rise,
  input wire logic dqs_fall,
  input wire logic dqs_n_rise,
  input wire logic dqs_n_fall,
  input wire logic dqs_oe,
  input wire logic core_req,
  // Status
  input wire logic stat_err
);
  // Link cycles in the current data run; an odd count means a cut burst
  logic [5:0] run_reg;
  logic [5:0] run_next;
  assign run_next = dq_oe ? run_reg + 6'h1 : 6'h0;
  always_ff @(posedge ck or negedge arst_n) begin
    if (!arst_n) begin
      run_reg <= 6'h0;
    end else begin
      run_reg <= run_next;
    end
  end

  property p_preamble;
    @(posedge ck) disable iff (!arst_n)
      $rose(dqs_oe) |-> !dq_oe && !dqs_rise && !dqs_fall
        && dqs_n_rise && dqs_n_fall ##1 dq_oe;
  endproperty
  a_preamble: assert property (p_preamble) else $error("bad read preamble");
  property p_postamble;
    @(posedge ck) disable iff (!arst_n)
      $fell(dq_oe) |-> dqs_oe && !dqs_rise && !dqs_fall && dqs_n_rise && dqs_n_fall;
  endproperty
  a_postamble: assert property (p_postamble) else $error("bad read postamble");
  property p_float;
    @(posedge ck) disable iff (!arst_n)
      $fell(dqs_oe) |-> !dq_oe && !$past(dq_oe);
  endproperty
  a_float: assert property (p_float) else $error("data not floated with strobe");
  property p_strobe;
    @(posedge ck) disable iff (!arst_n)
      dq_oe |-> dqs_oe && dqs_rise && !dqs_fall && !dqs_n_rise && dqs_n_fall;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not toggling with data");
  property p_core;
    @(posedge ck) disable iff (!arst_n)
      core_req |=> dq_oe;
  endproperty
  a_core: assert property (p_core) else $error("fetch not one cycle before data");
  property p_pulse;
    @(posedge ck) disable iff (!arst_n)
      core_req |=> !core_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("fetch request too long");
  property p_min_len;
    @(posedge ck) disable iff (!arst_n)
      $rose(dq_oe) |-> dq_oe [*2];
  endproperty
  a_min_len: assert property (p_min_len) else $error("burst shorter than chop");
  property p_whole;
    @(posedge ck) disable iff (!arst_n)
      $fell(dq_oe) |-> run_reg[0] == 1'b0 && run_reg != 6'h0;
  endproperty
  a_whole: assert property (p_whole) else $error("burst cut short");
  property p_sticky;
    @(posedge clk) disable iff (!arst_n)
      stat_err |=> stat_err;
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag dropped");

  c_seamless: cover property (@(posedge ck) disable iff (!arst_n) dq_oe [*8]);
  c_gap: cover property (@(posedge ck) disable iff (!arst_n) $fell(dq_oe) ##2 dq_oe);
  c_err: cover property (@(posedge clk) disable iff (!arst_n) $rose(stat_err));
endmodule

bind ddr3_command_read_timing ddr3_command_read_timing_monitor i_mon (
  .clk(clk), .arst_n(arst_n), .ck(ck), .dq_oe(dq_oe), .dqs_rise(dqs_rise),
  .dqs_fall(dqs_fall), .dqs_n_rise(dqs_n_rise), .dqs_n_fall(dqs_n_fall),
  .dqs_oe(dqs_oe), .core_req(core_req), .stat_err(stat_err)
);

// [ddr3_ctrl_model.sv]
`timescale 1ns/1ns
module ddr3_ctrl_model (
  // Link clock and command pins
  output logic                       ck,
  output logic                       cke,
  output logic                       cs_n,
  output logic                       ras_n,
  output logic                       cas_n,
  output logic                       we_n,
  output logic [ddr3_pkg::BA_W-1:0]  ba,
  output logic [ddr3_pkg::A_W-1:0]   addr
);
  import ddr3_pkg::*;
  int edges;
  // Offset start keeps link edges apart from system edges
  initial begin
    ck = 1'b0;
    #1;
    forever #6 ck = ~ck;
  end
  always @(posedge ck) edges <= edges + 1;
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = CMD_NOP;
    ba = '0;
    addr = '0;
  end
  // Caller owns spacing; returns just after the taking edge with its index
  task automatic issue(input logic [2:0] c, input logic [BA_W-1:0] b,
                       input logic [A_W-1:0] a, output int t);
    @(posedge ck);
    #1;
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    @(posedge ck);
    #1;
    t = edges;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = CMD_NOP;
    // Released pins show the inverse, never the old value
    ba = ~b;
    addr = ~a;
  endtask
endmodule

// [ddr3_command_read_timing_tb.sv]
`timescale 1ns/1ns
module ddr3_command_read_timing_tb;
  import ddr3_pkg::*;
  logic                clk;
  logic                arst_n;
  logic                ck;
  logic                cke;
  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  logic [BA_W-1:0]     ba;
  logic [A_W-1:0]      addr;
  logic [7:0]          dq_rise;
  logic [7:0]          dq_fall;
  logic                dq_oe;
  logic                dqs_rise;
  logic                dqs_fall;
  logic                dqs_n_rise;
  logic                dqs_n_fall;
  logic                dqs_oe;
  logic                core_req;
  logic [BA_W-1:0]     core_bank;
  logic [COL_W-1:0]    core_col;
  logic [63:0]         core_data;
  logic [A_W-1:0]      stat_mr0;
  logic [A_W-1:0]      stat_mr1;
  logic [A_W-1:0]      stat_mr2;
  logic [A_W-1:0]      stat_mr3;
  logic [NBANK-1:0]    stat_bank_open;
  logic                stat_zq_busy;
  logic                stat_err;
  logic [A_W-1:0]      mr [4];
  logic [A_W-1:0]      got [4];
  logic [A_W-1:0]      prev;
  logic [15:0]         exp_d [int];
  logic [1:0]          bl;
  logic [2:0]          b;
  int                  t;
  int                  cl;
  int                  al;
  int                  num_errors;
  int                  tests_run;

  ddr3_command_read_timing #(.DQ_W(8), .MAX_RL(32)) i_dut (
    .clk, .arst_n, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .dq_rise, .dq_fall, .dq_oe, .dqs_rise, .dqs_fall, .dqs_n_rise, .dqs_n_fall,
    .dqs_oe, .core_req, .core_bank, .core_col, .core_data, .stat_mr0, .stat_mr1,
    .stat_mr2, .stat_mr3, .stat_bank_open, .stat_zq_busy, .stat_err
  );
  ddr3_ctrl_model i_ctrl (.ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);

  function automatic logic [7:0] pat(input logic [2:0] bk, input logic [9:0] c, input int e);
    return 8'(c) + {bk, 5'h0} + 8'(e * 17);
  endfunction

  // Array answers while the fetch stands, so the edge that ends it takes the burst
  always @* begin
    for (int e = 0; e < 8; e++)
      core_data[e*8 +: 8] = core_req ? pat(core_bank, core_col, e)
                                     : ~pat(core_bank, core_col, e);
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ck);
  endtask

  task automatic chk_mr;
    got = '{stat_mr0, stat_mr1, stat_mr2, stat_mr3};
    for (int r = 0; r < 4; r++)
      chk(got[r], mr[r]);
  endtask

  task automatic rd(input logic [2:0] bk, input logic [9:0] c, input logic ap,
                    input logic a12, input int n, input int rl);
    i_ctrl.issue(CMD_RD, bk, {1'b0, a12, 1'b0, ap, c}, t);
    for (int j = 0; j < n; j += 2)
      exp_d[t + rl + j/2] = {pat(bk, c, j ^ {c[2], 2'b0}), pat(bk, c, (j + 1) ^ {c[2], 2'b0})};
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Data pins against the burst model on every link cycle
  always @(posedge ck) begin
    #2;
    if (exp_d.exists(i_ctrl.edges)) begin
      chk(dq_oe, 1'b1);
      chk({dq_rise, dq_fall}, exp_d[i_ctrl.edges]);
    end else begin
      chk(dq_oe, 1'b0);
    end
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #50000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(55579));
    arst_n = 1'b0;
    for (int r = 0; r < 4; r++)
      mr[r] = MR_RST[r*A_W +: A_W];
    repeat (5) @(posedge clk);
    #1;
    arst_n = 1'b1;
    idle(20);
    chk_mr();
    chk(stat_bank_open, 8'h00);
    for (int m = 0; m < 4; m++) begin
      prev = mr[0];
      cl = 5 + $urandom_range(3);
      al = $urandom_range(2);
      bl = (m == 3) ? 2'h2 : 2'(m != 0);
      mr[0] = {6'h0, 4'(cl), 2'h0, bl};
      mr[1] = 14'(al << 3);
      mr[2] = 14'($urandom);
      mr[3] = 14'($urandom) & 14'h3ffb;
      for (int r = 0; r < 4; r++) begin
        i_ctrl.issue(CMD_MRS, 3'(r), mr[r], t);
        idle(TMRD_CK - 2);
      end
      idle(2);
      chk(stat_mr0, prev);
      idle(TMOD_CK);
      chk_mr();
      b = 3'($urandom_range(7));
      i_ctrl.issue(CMD_ACT, b, 14'($urandom), t);
      idle(4);
      rd(b, 10'($urandom), 1'b0, m == 1, (m < 2) ? 8 : 4, cl + al);
      chk(stat_bank_open, 8'h01 << b);
      idle(TCCD_CK - 2);
      rd(b, 10'($urandom), 1'b1, m == 1, (m < 2) ? 8 : 4, cl + al);
      idle(40);
      chk(stat_bank_open, 8'h00);
    end
    chk(stat_err, 1'b0);
    i_ctrl.issue(CMD_ZQ, 3'h0, 14'h0000, t);
    idle(8);
    chk(stat_zq_busy, 1'b1);
    idle(TZQCS_CK + 8);
    chk(stat_zq_busy, 1'b0);
    // First long calibration since reset takes the longer window
    i_ctrl.issue(CMD_ZQ, 3'h0, 14'h0400, t);
    idle(TZQOPER_CK + 8);
    chk(stat_zq_busy, 1'b1);
    idle(TZQINIT_CK - TZQOPER_CK);
    chk(stat_zq_busy, 1'b0);
    // Read to a closed bank: refused, no data, error latched
    rd(3'h0, 10'h000, 1'b0, 1'b0, 0, 0);
    idle(20);
    chk(stat_err, 1'b1);
    tally_and_finish();
  end
endmodule
